//--- common/hct_defines.vh
// register map, field positions, reset values and codes of the hdlc channel tx block
`ifndef HCT_DEFINES_VH
`define HCT_DEFINES_VH

// register word indices, the byte address is four times the index
`define HCT_ADDR_MODE        6'h00
`define HCT_ADDR_TX_STATE    6'h01
`define HCT_ADDR_EVENT_MASK  6'h02
`define HCT_ADDR_STATUS      6'h03
`define HCT_ADDR_ENTRY_COUNT 6'h04

// mode register fields
`define HCT_MODE_NOF_LSB     0
`define HCT_MODE_NOF_MSB     3
`define HCT_MODE_IDLE_BIT    4
`define HCT_MODE_RESET       5'h00

// tx internal state word, msb-first numbering: field bit n sits at hardware bit 31-n
`define HCT_TS_BIT(n)        (31 - (n))
`define HCT_TS_BYTE_ORDER    28
`define HCT_TS_FC_MSB        27
`define HCT_TS_FC_LSB        24
`define HCT_TS_AT_MSB        26
`define HCT_TS_AT_LSB        24
`define HCT_TS_RESET         32'h00000000

// 16-bit mask and entry words, msb-first numbering: bit n at hardware bit 15-n
`define HCT_EV_BIT(n)        (15 - (n))
`define HCT_ENTRY_VALID      15
`define HCT_ENTRY_WRAP       14
`define HCT_ENTRY_CH_MSB     11
`define HCT_ENTRY_CH_LSB     6
`define HCT_EVENT_MASK_BITS  16'h303F
`define HCT_EVENT_MASK_RESET 16'h0000

`endif

//--- logic/hct_flag_seq.v
// flag sequencer: opening flags ahead of each frame and fill between frames
`timescale 1ns/1ps
`include "hct_defines.vh"
module hct_flag_seq #(
    parameter NOF_W = 4
) (
    input  wire             hclk,
    input  wire             hresetn,
    input  wire [NOF_W-1:0] min_flag_count,
    input  wire             idle_fill_select,
    input  wire             frame_ready,
    input  wire             flag_sent,
    input  wire             frame_end,
    output reg              send_flag,
    output reg              send_idle,
    output reg              frame_go,
    output reg  [1:0]       seq_state,
    output reg  [NOF_W:0]   flags_left
);
    localparam [1:0] SEQ_FILL  = 2'h0;
    localparam [1:0] SEQ_FLAGS = 2'h1;
    localparam [1:0] SEQ_DATA  = 2'h2;

    reg [1:0]     next_seq_state;
    reg [NOF_W:0] next_flags_left;

    always @* begin
        next_seq_state = seq_state;
        next_flags_left = flags_left;
        case (seq_state)
            SEQ_FILL: begin
                if (frame_ready) begin
                    next_seq_state = SEQ_FLAGS;
                    // count plus one, so a zero count still sends one flag
                    next_flags_left = {1'b0, min_flag_count} + {{NOF_W{1'b0}}, 1'b1};
                end
            end
            SEQ_FLAGS: begin
                if (flag_sent) begin
                    next_flags_left = flags_left - {{NOF_W{1'b0}}, 1'b1};
                    if (flags_left == {{NOF_W{1'b0}}, 1'b1}) begin
                        next_seq_state = SEQ_DATA;
                    end
                end
            end
            SEQ_DATA: begin
                if (frame_end) begin
                    next_seq_state = SEQ_FILL;
                end
            end
            default: begin
                next_seq_state = SEQ_FILL;
                next_flags_left = {(NOF_W+1){1'b0}};
            end
        endcase
    end

    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            seq_state <= SEQ_FILL;
            flags_left <= {(NOF_W+1){1'b0}};
            send_flag <= 1'b0;
            send_idle <= 1'b0;
            frame_go <= 1'b0;
        end else begin
            seq_state <= next_seq_state;
            flags_left <= next_flags_left;
            frame_go <= (seq_state == SEQ_FLAGS) && (next_seq_state == SEQ_DATA);
            // idle mode fills with idle patterns, otherwise with flags
            send_flag <= (next_seq_state == SEQ_FLAGS) ||
                         ((next_seq_state == SEQ_FILL) && !idle_fill_select);
            send_idle <= (next_seq_state == SEQ_FILL) && idle_fill_select;
        end
    end
endmodule // hct_flag_seq

//--- logic/hct_event_gate.v
// event gate: masks channel events and forms interrupt table entries
`timescale 1ns/1ps
`include "hct_defines.vh"
module hct_event_gate #(
    parameter CH_W = 6
) (
    input  wire            hclk,
    input  wire            hresetn,
    input  wire [15:0]     event_mask,
    input  wire [15:0]     event_word,
    input  wire [CH_W-1:0] channel_number,
    input  wire            table_wrap,
    output reg             irq_req,
    output reg             entry_wr,
    output reg  [15:0]     entry
);
    wire [15:0] gated;
    wire        any_event;

    // zero mask bit drops the event, a one passes it
    assign gated = event_word & event_mask & `HCT_EVENT_MASK_BITS;
    assign any_event = |gated;

    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            irq_req <= 1'b0;
            entry_wr <= 1'b0;
            entry <= 16'h0000;
        end else begin
            irq_req <= any_event;
            entry_wr <= any_event;
            if (any_event) begin
                entry <= gated;
                entry[`HCT_ENTRY_VALID] <= 1'b1;
                entry[`HCT_ENTRY_WRAP] <= table_wrap;
                entry[`HCT_ENTRY_CH_MSB:`HCT_ENTRY_CH_LSB] <= channel_number;
            end
        end
    end
endmodule // hct_event_gate

//--- logic/hct_channel.v
// hdlc channel tx state, mode and event mask registers behind an ahb-lite slave
//
// The AHB-Lite slave port and the placing of the registers were decided locally.
`timescale 1ns/1ps
`include "hct_defines.vh"
// Overview of operation
// - four-bit min_flag_count sets the least number of flags before each frame
// - a zero count still sends one flag before the first frame
// - in both fill modes, count plus one flags go out, then frame data
// - byte_order_select zero gives little-endian, one big-endian transmit buffer access
// - function-code variant: high byte bits 4-7 drive bus_function_code
// - address-type variant: high byte bits 5-7 drive bus_address_type
// - mask bits sit at the entry positions of their events
// - a zero mask bit stops both request and table entry
// - a one mask bit raises the request and logs the entry
// - entry carries valid, wrap, event flags and channel number
module hct_channel #(
    parameter       FC_VARIANT = 1,
    parameter       CH_W       = 6,
    parameter [5:0] CHANNEL    = 6'h00
) (
    input  wire        hclk,
    input  wire        hresetn,
    input  wire        hsel,
    input  wire [31:0] haddr,
    input  wire [1:0]  htrans,
    input  wire        hwrite,
    input  wire [2:0]  hsize,
    input  wire [31:0] hwdata,
    input  wire        hready,
    output wire        hreadyout,
    output wire        hresp,
    output reg  [31:0] hrdata,
    input  wire        frame_ready,
    input  wire        flag_sent,
    input  wire        frame_end,
    output wire        send_flag,
    output wire        send_idle,
    output wire        frame_go,
    output reg  [3:0]  bus_function_code,
    output reg  [2:0]  bus_address_type,
    output reg         byte_order_select,
    input  wire        non_idle_event,
    input  wire        idle_event,
    input  wire        max_frame_exceeded_event,
    input  wire        tx_underrun_event,
    input  wire        rx_frame_event,
    input  wire        no_rx_buffer_event,
    input  wire        tx_buffer_done_event,
    input  wire        rx_buffer_done_event,
    input  wire        table_wrap,
    output wire        irq_req,
    output wire        entry_wr,
    output wire [15:0] entry
);
    reg  [3:0]  min_flag_count;
    reg         idle_fill_select;
    reg  [31:0] tx_internal_state;
    reg  [15:0] event_mask;
    reg  [15:0] entry_count;

    reg         dp_wr;
    reg         dp_rd;
    reg         rd_done;
    reg  [5:0]  dp_addr;
    reg         dp_hit;
    reg  [31:0] rd_mux;

    wire        accept;
    wire        addr_in_range;
    wire [1:0]  seq_state;
    wire [4:0]  flags_left;
    reg  [15:0] event_word;

    // bus handshake: writes take no wait state, reads take one
    assign accept = hsel && htrans[1] && hready;
    assign addr_in_range = (haddr[31:8] == 24'h000000) && (haddr[1:0] == 2'h0);
    assign hreadyout = !dp_rd || rd_done;
    assign hresp = 1'b0;

    // address phase capture
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            dp_wr <= 1'b0;
            dp_rd <= 1'b0;
            rd_done <= 1'b0;
            dp_addr <= 6'h00;
            dp_hit <= 1'b0;
        end else if (hready) begin
            dp_wr <= accept && hwrite;
            dp_rd <= accept && !hwrite;
            rd_done <= 1'b0;
            dp_addr <= haddr[7:2];
            dp_hit <= addr_in_range;
        end else if (dp_rd) begin
            rd_done <= 1'b1;
        end
    end

    // read data mux, unmapped addresses read zero
    always @* begin
        rd_mux = 32'h00000000;
        if (dp_hit) begin
            case (dp_addr)
                `HCT_ADDR_MODE: begin
                    rd_mux[`HCT_MODE_NOF_MSB:`HCT_MODE_NOF_LSB] = min_flag_count;
                    rd_mux[`HCT_MODE_IDLE_BIT] = idle_fill_select;
                end
                `HCT_ADDR_TX_STATE: begin
                    rd_mux = tx_internal_state;
                end
                `HCT_ADDR_EVENT_MASK: begin
                    rd_mux[15:0] = event_mask;
                end
                `HCT_ADDR_STATUS: begin
                    rd_mux[1:0] = seq_state;
                    rd_mux[12:8] = flags_left;
                end
                `HCT_ADDR_ENTRY_COUNT: begin
                    rd_mux[15:0] = entry_count;
                end
                default: begin
                    rd_mux = 32'h00000000;
                end
            endcase
        end
    end

    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hrdata <= 32'h00000000;
        end else if (dp_rd && !rd_done) begin
            hrdata <= rd_mux;
        end
    end

    // register writes in the data phase
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            min_flag_count <= 4'h0;
            idle_fill_select <= 1'b0;
            tx_internal_state <= `HCT_TS_RESET;
            event_mask <= `HCT_EVENT_MASK_RESET;
        end else if (dp_wr && dp_hit) begin
            case (dp_addr)
                `HCT_ADDR_MODE: begin
                    min_flag_count <= hwdata[`HCT_MODE_NOF_MSB:`HCT_MODE_NOF_LSB];
                    idle_fill_select <= hwdata[`HCT_MODE_IDLE_BIT];
                end
                `HCT_ADDR_TX_STATE: begin
                    tx_internal_state <= hwdata;
                end
                `HCT_ADDR_EVENT_MASK: begin
                    // only event positions are kept, reserved bits read zero
                    event_mask <= hwdata[15:0] & `HCT_EVENT_MASK_BITS;
                end
                default: begin
                    event_mask <= event_mask;
                end
            endcase
        end
    end

    // dma cycle attributes taken from the tx state high byte
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            bus_function_code <= 4'h0;
            bus_address_type <= 3'h0;
            byte_order_select <= 1'b0;
        end else begin
            // high byte bit 3 is hardware bit 28 in lsb-first naming
            byte_order_select <= tx_internal_state[`HCT_TS_BYTE_ORDER];
            if (FC_VARIANT != 0) begin
                bus_function_code <= tx_internal_state[`HCT_TS_FC_MSB:`HCT_TS_FC_LSB];
                bus_address_type <= 3'h0;
            end else begin
                bus_function_code <= 4'h0;
                bus_address_type <= tx_internal_state[`HCT_TS_AT_MSB:`HCT_TS_AT_LSB];
            end
        end
    end

    // events placed at their entry positions
    always @* begin
        event_word = 16'h0000;
        event_word[`HCT_EV_BIT(2)] = non_idle_event;
        event_word[`HCT_EV_BIT(3)] = idle_event;
        event_word[`HCT_EV_BIT(10)] = max_frame_exceeded_event;
        event_word[`HCT_EV_BIT(11)] = tx_underrun_event;
        event_word[`HCT_EV_BIT(12)] = rx_frame_event;
        event_word[`HCT_EV_BIT(13)] = no_rx_buffer_event;
        event_word[`HCT_EV_BIT(14)] = tx_buffer_done_event;
        event_word[`HCT_EV_BIT(15)] = rx_buffer_done_event;
    end

    // count of entries written, for software bookkeeping
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            entry_count <= 16'h0000;
        end else if (entry_wr) begin
            entry_count <= entry_count + 16'h0001;
        end
    end

    hct_flag_seq #(
        .NOF_W            (4)
    ) u_flag_seq (
        .hclk             (hclk),
        .hresetn          (hresetn),
        .min_flag_count   (min_flag_count),
        .idle_fill_select (idle_fill_select),
        .frame_ready      (frame_ready),
        .flag_sent        (flag_sent),
        .frame_end        (frame_end),
        .send_flag        (send_flag),
        .send_idle        (send_idle),
        .frame_go         (frame_go),
        .seq_state        (seq_state),
        .flags_left       (flags_left)
    );

    hct_event_gate #(
        .CH_W             (CH_W)
    ) u_event_gate (
        .hclk             (hclk),
        .hresetn          (hresetn),
        .event_mask       (event_mask),
        .event_word       (event_word),
        .channel_number   (CHANNEL[CH_W-1:0]),
        .table_wrap       (table_wrap),
        .irq_req          (irq_req),
        .entry_wr         (entry_wr),
        .entry            (entry)
    );
endmodule // hct_channel

//--- verification/hct_channel_properties.sv
// checker of the channel block: bus, flag framing, tx state and event properties
`timescale 1ns/1ps
module hct_channel_properties #(
    parameter       FC_VARIANT = 1,
    parameter [5:0] CHANNEL    = 6'h00
) (
    input wire        hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp,
    input wire [31:0] haddr, hwdata,
    input wire [1:0]  htrans,
    input wire        flag_sent, send_flag, frame_go, byte_order_select,
    input wire [3:0]  bus_function_code,
    input wire [2:0]  bus_address_type,
    input wire        non_idle_event, idle_event, max_frame_exceeded_event,
    input wire        tx_underrun_event, rx_frame_event, no_rx_buffer_event,
    input wire        tx_buffer_done_event, rx_buffer_done_event,
    input wire        table_wrap, irq_req, entry_wr,
    input wire [15:0] entry
);
    reg         wr_ts, wr_mk;
    reg  [31:0] ts_sh;
    reg  [15:0] mk_sh;
    wire [15:0] ev_word = {2'h0, non_idle_event, idle_event, 6'h00, max_frame_exceeded_event,
                           tx_underrun_event, rx_frame_event, no_rx_buffer_event,
                           tx_buffer_done_event, rx_buffer_done_event};
    wire [15:0] ev_on = ev_word & mk_sh;
    wire [3:0]  x_fc  = (FC_VARIANT != 0) ? ts_sh[27:24] : 4'h0;
    wire [2:0]  x_at  = (FC_VARIANT != 0) ? 3'h0 : ts_sh[26:24];
    // shadows of the tx state and mask words, taken from bus writes
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_ts <= 1'b0;
            wr_mk <= 1'b0;
            ts_sh <= 32'h0000_0000;
            mk_sh <= 16'h0000;
        end else if (hready) begin
            wr_ts <= hsel && htrans[1] && hwrite && haddr == 32'h0000_0004;
            wr_mk <= hsel && htrans[1] && hwrite && haddr == 32'h0000_0008;
            if (wr_ts) ts_sh <= hwdata;
            if (wr_mk) mk_sh <= hwdata[15:0] & 16'h303F;
        end
    end
    default clocking @(posedge hclk); endclocking
    default disable iff (!hresetn);
    property p_okay; hresp == 1'b0; endproperty
    property p_rd_wait; hsel && htrans[1] && hready && !hwrite |=> !hreadyout ##1 hreadyout;
    endproperty
    property p_go_flag; frame_go |-> $past(flag_sent); endproperty
    property p_go_data; frame_go |-> !send_flag ##1 !frame_go; endproperty
    property p_order; byte_order_select != ts_sh[28] |=> byte_order_select == ts_sh[28];
    endproperty
    property p_code; (bus_function_code != x_fc || bus_address_type != x_at)
        |=> (bus_function_code == x_fc && bus_address_type == x_at); endproperty
    property p_masked; ev_on == 16'h0000 |=> !irq_req && !entry_wr; endproperty
    property p_unmasked; ev_on != 16'h0000 |=> irq_req && entry_wr; endproperty
    property p_bits; entry_wr |-> (entry & 16'h303F) == $past(ev_on); endproperty
    property p_hdr; entry_wr |-> entry[15] && entry[14] == $past(table_wrap)
        && entry[11:6] == CHANNEL; endproperty
    a_okay: assert property (p_okay) else $error("response not okay");
    a_rd_wait: assert property (p_rd_wait) else $error("read wait state wrong");
    a_go_flag: assert property (p_go_flag) else $error("frame start without flag");
    a_go_data: assert property (p_go_data) else $error("frame start pulse wrong");
    a_order: assert property (p_order) else $error("byte order output stale");
    a_code: assert property (p_code) else $error("bus code output wrong");
    a_masked: assert property (p_masked) else $error("masked event reported");
    a_unmasked: assert property (p_unmasked) else $error("event not reported");
    a_bits: assert property (p_bits) else $error("entry event bits wrong");
    a_hdr: assert property (p_hdr) else $error("entry header wrong");
    c_entry: cover property (entry_wr);
    c_go: cover property (frame_go);
    c_rd: cover property (!hreadyout);
endmodule // hct_channel_properties

bind hct_channel hct_channel_properties #(.FC_VARIANT(FC_VARIANT), .CHANNEL(CHANNEL)) u_props (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .hwrite(hwrite), .hready(hready),
    .hreadyout(hreadyout), .hresp(hresp), .haddr(haddr), .hwdata(hwdata), .htrans(htrans),
    .flag_sent(flag_sent), .send_flag(send_flag), .frame_go(frame_go),
    .byte_order_select(byte_order_select), .bus_function_code(bus_function_code),
    .bus_address_type(bus_address_type), .non_idle_event(non_idle_event),
    .idle_event(idle_event), .max_frame_exceeded_event(max_frame_exceeded_event),
    .tx_underrun_event(tx_underrun_event), .rx_frame_event(rx_frame_event),
    .no_rx_buffer_event(no_rx_buffer_event), .tx_buffer_done_event(tx_buffer_done_event),
    .rx_buffer_done_event(rx_buffer_done_event), .table_wrap(table_wrap),
    .irq_req(irq_req), .entry_wr(entry_wr), .entry(entry));

//--- verification/hct_serializer_model.sv
// serializer model: answers flag requests after a gap and ends frames
`timescale 1ns/1ps
module hct_serializer_model (
    input  wire       hclk,
    input  wire       hresetn,
    input  wire [1:0] gap,
    input  wire       send_flag,
    input  wire       frame_go,
    output reg        flag_sent,
    output reg        frame_end
);
    reg [1:0] cnt;
    reg [2:0] fcnt;
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            cnt       <= 2'h0;
            fcnt      <= 3'h0;
            flag_sent <= 1'b0;
            frame_end <= 1'b0;
        end else begin
            cnt       <= (send_flag && cnt != gap) ? cnt + 2'h1 : 2'h0;
            flag_sent <= send_flag && cnt == gap;
            frame_end <= fcnt == 3'h1;
            fcnt      <= frame_go ? 3'h4 : (fcnt != 3'h0) ? fcnt - 3'h1 : 3'h0;
        end
    end
endmodule // hct_serializer_model

//--- verification/tb_hct_channel.sv
// testbench of the channel block: register access, flag framing and event entries
`timescale 1ns/1ps
`include "hct_defines.vh"
module tb_hct_channel;
    localparam [5:0] CH = 6'h2A;
    reg         hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0;
    reg         frame_ready = 1'b0, table_wrap = 1'b0;
    reg  [31:0] haddr = 32'h0, hwdata = 32'h0, q, d;
    reg  [1:0]  htrans = 2'h0, gap = 2'h0;
    reg  [2:0]  hsize = 3'h0;
    reg  [15:0] ev = 16'h0;
    wire        hready, hreadyout, flag_sent, frame_end, send_flag, send_idle, frame_go;
    wire [31:0] hrdata;
    wire [15:0] entry;
    wire [3:0]  fc;
    wire [2:0]  at;
    wire        order, irq, ewr;
    wire        order_at;
    wire [3:0]  fc_at;
    wire [2:0]  at_at;
    int         num_errors = 0, cmp_count = 0, i, n, cnt;
    int         pos[8] = '{13, 12, 5, 4, 3, 2, 1, 0};
    int         modes[4] = '{0, 3, 15, 17};
    assign hready = hreadyout;
    initial forever #2.5 hclk = ~hclk;
    hct_channel #(.CHANNEL(CH)) dut (
        .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
        .hreadyout(hreadyout), .hresp(), .hrdata(hrdata), .frame_ready(frame_ready),
        .flag_sent(flag_sent), .frame_end(frame_end), .send_flag(send_flag),
        .send_idle(send_idle), .frame_go(frame_go), .bus_function_code(fc),
        .bus_address_type(at), .byte_order_select(order), .non_idle_event(ev[13]),
        .idle_event(ev[12]), .max_frame_exceeded_event(ev[5]), .tx_underrun_event(ev[4]),
        .rx_frame_event(ev[3]), .no_rx_buffer_event(ev[2]), .tx_buffer_done_event(ev[1]),
        .rx_buffer_done_event(ev[0]), .table_wrap(table_wrap), .irq_req(irq),
        .entry_wr(ewr), .entry(entry));
    // address-type variant on the same bus, answers in step with dut
    hct_channel #(.FC_VARIANT(0), .CHANNEL(CH)) dut_at (
        .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready), .hreadyout(),
        .hresp(), .hrdata(), .frame_ready(1'b0), .flag_sent(1'b0), .frame_end(1'b0),
        .send_flag(), .send_idle(), .frame_go(), .bus_function_code(fc_at),
        .bus_address_type(at_at), .byte_order_select(order_at), .non_idle_event(1'b0),
        .idle_event(1'b0), .max_frame_exceeded_event(1'b0), .tx_underrun_event(1'b0),
        .rx_frame_event(1'b0), .no_rx_buffer_event(1'b0), .tx_buffer_done_event(1'b0),
        .rx_buffer_done_event(1'b0), .table_wrap(1'b0), .irq_req(), .entry_wr(),
        .entry());
    hct_serializer_model u_ser (.hclk(hclk), .hresetn(hresetn), .gap(gap),
        .send_flag(send_flag), .frame_go(frame_go), .flag_sent(flag_sent),
        .frame_end(frame_end));
    task give_verdict;
        $display("comparisons %0d, errors %0d", cmp_count, num_errors);
        if (num_errors == 0 && cmp_count > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask
    task chk(input [31:0] got, input [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            num_errors++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task guard(input int k);
        if (k >= 200) begin
            num_errors++;
            give_verdict;
        end
    endtask
    task wait_rdy;
        n = 0;
        do begin
            @(posedge hclk);
            n++;
        end while (hready !== 1'b1 && n < 200);
        guard(n);
    endtask
    task xfer(input w, input [5:0] idx, input [31:0] wd);
        hsel   <= 1'b1;
        haddr  <= {24'h0, idx, 2'h0};
        htrans <= 2'h2;
        hwrite <= w;
        hsize  <= 3'h2;
        wait_rdy;
        hsel   <= 1'b0;
        htrans <= 2'h0;
        hwdata <= wd;
        wait_rdy;
        q = hrdata;
    endtask
    task pulse(input [15:0] e, input w);
        @(posedge hclk);
        ev         <= e;
        table_wrap <= w;
        @(posedge hclk);
        ev         <= 16'h0;
        #1;
    endtask
    initial begin
        repeat (10) @(posedge hclk);
        hresetn <= 1'b1;
        for (i = 0; i < 4; i++) begin
            xfer(0, (i == 3) ? 6'h3F : i[5:0], 32'h0);
            chk(q, 32'h0);
        end
        chk({order, fc, at, order_at, fc_at, at_at}, 32'h0);
        xfer(1, 6'h3F, 32'hFFFF_FFFF);
        xfer(1, `HCT_ADDR_EVENT_MASK, 32'hFFFF_FFFF);
        xfer(0, `HCT_ADDR_EVENT_MASK, 32'h0);
        chk(q, 32'h0000_303F);
        for (i = 0; i < 3; i++) begin
            d = (i == 0) ? 32'h3800_0000 : (i == 1) ? 32'h3000_0000 : 32'h3300_0000;
            xfer(1, `HCT_ADDR_TX_STATE, d);
            xfer(0, `HCT_ADDR_TX_STATE, 32'h0);
            chk(q, d);
            chk({order, fc, at}, {d[28], d[27:24], 3'h0});
            chk({order_at, fc_at, at_at}, {d[28], 4'h0, d[26:24]});
        end
        for (i = 0; i < 8; i++) begin
            pulse(16'h1 << pos[i], i[0]);
            d = 32'h8000 | i[0] << 14 | CH << 6 | 1 << pos[i];
            chk({irq, ewr, entry}, {2'h3, d[15:0]});
        end
        xfer(1, `HCT_ADDR_EVENT_MASK, 32'h0000_2010);
        pulse(16'h303F, 1'b0);
        chk({irq, ewr, entry}, {2'h3, 16'hA010 | CH << 6});
        xfer(1, `HCT_ADDR_EVENT_MASK, 32'h0);
        pulse(16'h303F, 1'b0);
        chk({irq, ewr}, 2'h0);
        xfer(0, `HCT_ADDR_ENTRY_COUNT, 32'h0);
        chk(q, 32'h0000_0009);
        for (i = 0; i < 4; i++) begin
            xfer(1, `HCT_ADDR_MODE, modes[i]);
            gap <= i[1:0];
            @(posedge hclk);
            #1;
            chk({send_flag, send_idle}, (modes[i] > 15) ? 2'h1 : 2'h2);
            @(posedge hclk);
            frame_ready <= 1'b1;
            @(posedge hclk);
            frame_ready <= 1'b0;
            cnt = 0;
            n = 0;
            #1;
            while (frame_go !== 1'b1 && n < 200) begin
                if (flag_sent === 1'b1) cnt++;
                @(posedge hclk);
                #1;
                n++;
            end
            guard(n);
            chk(cnt, (modes[i] & 15) + 1);
            repeat (8) @(posedge hclk);
            xfer(0, `HCT_ADDR_STATUS, 32'h0);
            chk({q[12:8], q[1:0]}, 7'h00);
        end
        give_verdict;
    end
endmodule // tb_hct_channel
